// ===== hdl/tcm_pkg.sv
// Constants, types and helpers of the timer compare-output mode block
package tcm_pkg;

   localparam int CNT_W = 8;
   localparam int ADDR_W = 3;

   // Register offsets
   localparam logic [2:0] ADDR_CTRL_A = 3'h0;
   localparam logic [2:0] ADDR_CTRL_B = 3'h1;
   localparam logic [2:0] ADDR_COUNT = 3'h2;
   localparam logic [2:0] ADDR_CMP_A = 3'h3;
   localparam logic [2:0] ADDR_CMP_B = 3'h4;
   localparam logic [2:0] ADDR_STATUS = 3'h5;

   // Field positions
   localparam int CHAN_A_MODE_LSB = 6;
   localparam int CHAN_B_MODE_LSB = 4;
   localparam int WAVE_LOW_LSB = 0;
   localparam int WAVE_HIGH_BIT = 3;
   localparam int RUN_BIT = 0;
   localparam int ST_OVF_BIT = 0;
   localparam int ST_MATCH_A_BIT = 1;
   localparam int ST_MATCH_B_BIT = 2;

   // Reset values and write masks
   localparam logic [7:0] CTRL_A_RST = 8'h00;
   localparam logic [7:0] CTRL_B_RST = 8'h00;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] COUNT_RST = 8'h00;
   localparam logic [7:0] CMP_RST = 8'h00;
   localparam logic [7:0] CTRL_A_WMASK = 8'hf3;
   localparam logic [7:0] CTRL_B_WMASK = 8'h09;
   localparam logic [7:0] STATUS_MASK = 8'h07;

   localparam logic [7:0] MAX_VAL = 8'hff;
   localparam logic [7:0] BOTTOM_VAL = 8'h00;

   // Waveform mode codes
   localparam logic [2:0] WM_NORMAL = 3'h0;
   localparam logic [2:0] WM_PHASE_FIX = 3'h1;
   localparam logic [2:0] WM_CLR_MATCH = 3'h2;
   localparam logic [2:0] WM_FAST_FIX = 3'h3;
   localparam logic [2:0] WM_PHASE_CMP = 3'h5;
   localparam logic [2:0] WM_FAST_CMP = 3'h7;

   // Compare output mode codes
   localparam logic [1:0] OM_OFF = 2'h0;
   localparam logic [1:0] OM_TOGGLE = 2'h1;
   localparam logic [1:0] OM_CLEAR = 2'h2;
   localparam logic [1:0] OM_SET = 2'h3;

   typedef enum logic [4:0] {
      WC_NORMAL = 5'b00001,
      WC_CLR_MATCH = 5'b00010,
      WC_FAST = 5'b00100,
      WC_PHASE = 5'b01000,
      WC_RSVD = 5'b10000
   } tcm_wclass_t;

   typedef enum logic [1:0] {
      DIR_UP = 2'b01,
      DIR_DOWN = 2'b10
   } tcm_dir_t;

   function automatic tcm_wclass_t wave_class(input logic [2:0] m);
      tcm_wclass_t c;
      c = WC_RSVD;
      case (m)
         WM_NORMAL: c = WC_NORMAL;
         WM_CLR_MATCH: c = WC_CLR_MATCH;
         WM_FAST_FIX, WM_FAST_CMP: c = WC_FAST;
         WM_PHASE_FIX, WM_PHASE_CMP: c = WC_PHASE;
         default: c = WC_RSVD;
      endcase
      return c;
   endfunction

   function automatic logic top_from_cmp(input logic [2:0] m);
      return (m == WM_CLR_MATCH) || (m == WM_PHASE_CMP) || (m == WM_FAST_CMP);
   endfunction

endpackage

// ===== hdl/tcm_cmp_buf.sv
// Compare value buffer with immediate or at-top update
module tcm_cmp_buf
   import tcm_pkg::*;
#(
   parameter int W = CNT_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Software write
   input wire logic wr,
   input wire logic [W-1:0] wdata,
   // Update moment
   input wire logic update,
   // Values
   output logic [W-1:0] buf_q,
   output logic [W-1:0] act_q
);

   logic [W-1:0] buf_d;
   logic [W-1:0] act_d;

   always_comb begin
      buf_d = wr ? wdata : buf_q;
      act_d = update ? buf_d : act_q;
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         buf_q <= W'(CMP_RST);
         act_q <= W'(CMP_RST);
      end else begin
         buf_q <= buf_d;
         act_q <= act_d;
      end
   end

endmodule

// ===== hdl/tcm_out_unit.sv
// Compare output waveform unit for one channel
module tcm_out_unit
   import tcm_pkg::*;
#(
   parameter bit CHAN_A = 1'b1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Configuration
   input wire logic [1:0] mode,
   input wire tcm_wclass_t wclass,
   input wire logic wave_high,
   // Counter events
   input wire logic match,
   input wire logic at_top,
   input wire logic counting_down,
   input wire logic cmp_eq_top,
   // Output
   output logic wave_q,
   output logic override
);

   logic wave_d;
   logic pwm;
   logic ignore;
   logic eff_match;

   always_comb begin
      pwm = (wclass == WC_FAST) || (wclass == WC_PHASE);
      // Code one in PWM: channel A only with high mode bit, B never
      override = (mode != OM_OFF)
         && !(pwm && mode == OM_TOGGLE && (!CHAN_A || !wave_high));
      ignore = pwm && mode[1] && cmp_eq_top;
      eff_match = match && !ignore;
      wave_d = wave_q;
      if (wclass == WC_NORMAL || wclass == WC_CLR_MATCH) begin
         if (match) begin
            case (mode)
               OM_TOGGLE: wave_d = ~wave_q;
               OM_CLEAR: wave_d = 1'b0;
               OM_SET: wave_d = 1'b1;
               default: wave_d = wave_q;
            endcase
         end
      end else if (pwm) begin
         if (eff_match && mode == OM_TOGGLE && override) begin
            wave_d = ~wave_q;
         end
         if (wclass == WC_FAST) begin
            if (eff_match && mode[1]) begin
               wave_d = (mode == OM_SET);
            end
            if (at_top && mode[1]) begin
               wave_d = (mode == OM_CLEAR);
            end
         end else begin
            if (eff_match && mode == OM_CLEAR) begin
               wave_d = counting_down;
            end
            if (eff_match && mode == OM_SET) begin
               wave_d = !counting_down;
            end
            if (at_top && ignore) begin
               wave_d = (mode == OM_CLEAR);
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         wave_q <= 1'b0;
      end else begin
         wave_q <= wave_d;
      end
   end

endmodule

// ===== hdl/tcm_top.sv
// Timer counter with compare-output mode decode and register port
module tcm_top
   import tcm_pkg::*;
(
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic NRST,
   // Register port
   input wire logic [ADDR_W-1:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   // Compare outputs toward the port pins
   output logic CHAN_A_WAVE_PIN,
   output logic CHAN_A_OVERRIDE,
   output logic CHAN_B_WAVE_PIN,
   output logic CHAN_B_OVERRIDE,
   // Status
   output logic OVERFLOW_FLAG,
   output logic [CNT_W-1:0] COUNTER_VALUE
);

   logic [7:0] ctrl_a_q, ctrl_a_d;
   logic [7:0] ctrl_b_q, ctrl_b_d;
   logic [7:0] status_q, status_d;
   logic [7:0] rdata_q, rdata_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic block_q, block_d;
   tcm_dir_t dir_q, dir_d;

   logic [2:0] waveform_mode;
   tcm_wclass_t wclass;
   logic [1:0] chan_a_output_mode;
   logic [1:0] chan_b_output_mode;
   logic running;
   logic [CNT_W-1:0] top_val;
   logic at_top;
   logic top_event;
   logic ovf_event;
   logic match_a, match_b;
   logic cmp_update;
   logic wr_ctrl_a, wr_ctrl_b, wr_count, wr_cmp_a, wr_cmp_b, wr_status;
   logic [CNT_W-1:0] cmp_a_buf, cmp_a_act;
   logic [CNT_W-1:0] cmp_b_buf, cmp_b_act;
   logic wave_a, wave_b, ovr_a, ovr_b;

   // Mode decode
   always_comb begin
      waveform_mode = {ctrl_b_q[WAVE_HIGH_BIT],
                       ctrl_a_q[WAVE_LOW_LSB +: 2]};
      wclass = wave_class(waveform_mode);
      chan_a_output_mode = ctrl_a_q[CHAN_A_MODE_LSB +: 2];
      chan_b_output_mode = ctrl_a_q[CHAN_B_MODE_LSB +: 2];
      running = ctrl_b_q[RUN_BIT] && (wclass != WC_RSVD);
      top_val = top_from_cmp(waveform_mode) ? cmp_a_act : MAX_VAL;
      at_top = (cnt_q == top_val);
      top_event = running && at_top;
   end

   // Register write decode
   always_comb begin
      wr_ctrl_a = REG_WR && (REG_ADDR == ADDR_CTRL_A);
      wr_ctrl_b = REG_WR && (REG_ADDR == ADDR_CTRL_B);
      wr_count = REG_WR && (REG_ADDR == ADDR_COUNT);
      wr_cmp_a = REG_WR && (REG_ADDR == ADDR_CMP_A);
      wr_cmp_b = REG_WR && (REG_ADDR == ADDR_CMP_B);
      wr_status = REG_WR && (REG_ADDR == ADDR_STATUS);
   end

   // Counter sequence and events
   always_comb begin
      cnt_d = cnt_q;
      dir_d = dir_q;
      block_d = wr_count;
      ovf_event = 1'b0;
      if (running) begin
         unique case (wclass)
            WC_NORMAL: begin
               cnt_d = cnt_q + 1'b1;
               ovf_event = (cnt_q == MAX_VAL);
            end
            WC_CLR_MATCH: begin
               cnt_d = at_top ? BOTTOM_VAL : cnt_q + 1'b1;
               ovf_event = (cnt_q == MAX_VAL);
            end
            WC_FAST: begin
               cnt_d = at_top ? BOTTOM_VAL : cnt_q + 1'b1;
               ovf_event = top_from_cmp(waveform_mode) ? at_top
                  : (cnt_q == MAX_VAL);
            end
            WC_PHASE: begin
               // Up to top, one cycle there, then down to bottom
               if (dir_q == DIR_UP) begin
                  if (at_top) begin
                     dir_d = DIR_DOWN;
                     cnt_d = (cnt_q == BOTTOM_VAL) ? cnt_q : cnt_q - 1'b1;
                  end else begin
                     cnt_d = cnt_q + 1'b1;
                  end
               end else begin
                  if (cnt_q == BOTTOM_VAL) begin
                     dir_d = DIR_UP;
                     cnt_d = at_top ? cnt_q : cnt_q + 1'b1;
                     ovf_event = 1'b1;
                  end else begin
                     cnt_d = cnt_q - 1'b1;
                  end
               end
            end
            WC_RSVD: cnt_d = cnt_q;
         endcase
      end
      if (wclass != WC_PHASE) begin
         dir_d = DIR_UP;
      end
      if (wr_count) begin
         cnt_d = REG_WDATA[CNT_W-1:0];
      end
      match_a = running && !block_q && (cnt_q == cmp_a_act);
      match_b = running && !block_q && (cnt_q == cmp_b_act);
      // Immediate in non-PWM modes, at top in PWM modes
      cmp_update = (wclass == WC_NORMAL) || (wclass == WC_CLR_MATCH) || (wclass == WC_RSVD)
         || top_event;
   end

   always_ff @(posedge REF_CLK) begin
      if (!NRST) begin
         cnt_q <= CNT_W'(COUNT_RST);
         dir_q <= DIR_UP;
         block_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         dir_q <= dir_d;
         block_q <= block_d;
      end
   end

   // Registers and read port
   always_comb begin
      ctrl_a_d = wr_ctrl_a ? (REG_WDATA & CTRL_A_WMASK) : ctrl_a_q;
      ctrl_b_d = wr_ctrl_b ? (REG_WDATA & CTRL_B_WMASK) : ctrl_b_q;
      // Hardware set wins over a write-one clear in the same cycle
      status_d = status_q & ~(wr_status ? REG_WDATA : 8'h00);
      status_d[ST_OVF_BIT] = status_d[ST_OVF_BIT] | ovf_event;
      status_d[ST_MATCH_A_BIT] = status_d[ST_MATCH_A_BIT] | match_a;
      status_d[ST_MATCH_B_BIT] = status_d[ST_MATCH_B_BIT] | match_b;
      status_d = status_d & STATUS_MASK;
      rdata_d = 8'h00;
      if (REG_RD) begin
         case (REG_ADDR)
            ADDR_CTRL_A: rdata_d = ctrl_a_q & CTRL_A_WMASK;
            ADDR_CTRL_B: rdata_d = ctrl_b_q;
            ADDR_COUNT: rdata_d = 8'(cnt_q);
            ADDR_CMP_A: rdata_d = 8'(cmp_a_buf);
            ADDR_CMP_B: rdata_d = 8'(cmp_b_buf);
            ADDR_STATUS: rdata_d = status_q;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!NRST) begin
         ctrl_a_q <= CTRL_A_RST;
         ctrl_b_q <= CTRL_B_RST;
         status_q <= STATUS_RST;
         rdata_q <= 8'h00;
      end else begin
         ctrl_a_q <= ctrl_a_d;
         ctrl_b_q <= ctrl_b_d;
         status_q <= status_d;
         rdata_q <= rdata_d;
      end
   end

   tcm_cmp_buf #(.W(CNT_W)) u_cmp_a (
      .clk(REF_CLK),
      .nrst(NRST),
      .wr(wr_cmp_a),
      .wdata(REG_WDATA[CNT_W-1:0]),
      .update(cmp_update),
      .buf_q(cmp_a_buf),
      .act_q(cmp_a_act)
   );

   tcm_cmp_buf #(.W(CNT_W)) u_cmp_b (
      .clk(REF_CLK),
      .nrst(NRST),
      .wr(wr_cmp_b),
      .wdata(REG_WDATA[CNT_W-1:0]),
      .update(cmp_update),
      .buf_q(cmp_b_buf),
      .act_q(cmp_b_act)
   );

   tcm_out_unit #(.CHAN_A(1'b1)) u_out_a (
      .clk(REF_CLK),
      .nrst(NRST),
      .mode(chan_a_output_mode),
      .wclass(wclass),
      .wave_high(waveform_mode[2]),
      .match(match_a),
      .at_top(top_event),
      .counting_down(dir_q == DIR_DOWN),
      .cmp_eq_top(cmp_a_act == top_val),
      .wave_q(wave_a),
      .override(ovr_a)
   );

   tcm_out_unit #(.CHAN_A(1'b0)) u_out_b (
      .clk(REF_CLK),
      .nrst(NRST),
      .mode(chan_b_output_mode),
      .wclass(wclass),
      .wave_high(waveform_mode[2]),
      .match(match_b),
      .at_top(top_event),
      .counting_down(dir_q == DIR_DOWN),
      .cmp_eq_top(cmp_b_act == top_val),
      .wave_q(wave_b),
      .override(ovr_b)
   );

   // Pin direction stays with the port logic outside
   always_comb begin
      REG_RDATA = rdata_q;
      CHAN_A_WAVE_PIN = wave_a;
      CHAN_A_OVERRIDE = ovr_a;
      CHAN_B_WAVE_PIN = wave_b;
      CHAN_B_OVERRIDE = ovr_b;
      OVERFLOW_FLAG = status_q[ST_OVF_BIT];
      COUNTER_VALUE = cnt_q;
   end

endmodule

// ===== testbench/tcm_pin_model.sv
// Port pin model fed by one compare output and its direction bit
module tcm_pin_model (
   // Pin sources
   input wire logic wave,
   input wire logic ovr,
   input wire logic ddr,
   input wire logic port_out,
   // Pad level
   output logic pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // Driver off leaves the pad on its pull-up
   assign pin = ddr ? (ovr ? wave : port_out) : 1'b1;
endmodule

// ===== testbench/tcm_top_props.sv
// Concurrent checks on the ports of the compare-output block
module tcm_props
   import tcm_pkg::*;
(
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic NRST,
   // Register port
   input wire logic [ADDR_W-1:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_RDATA,
   // Compare outputs
   input wire logic CHAN_A_WAVE_PIN,
   input wire logic CHAN_A_OVERRIDE,
   input wire logic CHAN_B_WAVE_PIN,
   input wire logic CHAN_B_OVERRIDE,
   // Status
   input wire logic OVERFLOW_FLAG,
   input wire logic [CNT_W-1:0] COUNTER_VALUE
);
   logic [7:0] sa_q, sa_d, sb_q, sb_d, sc_q, sc_d;
   logic [2:0] wm;
   logic pwm, run, cw, ea, eb;
   // Shadow copies of both control registers and compare A
   always_comb begin
      sa_d = sa_q;
      sb_d = sb_q;
      sc_d = sc_q;
      if (REG_WR && REG_ADDR == ADDR_CTRL_A) sa_d = REG_WDATA & CTRL_A_WMASK;
      if (REG_WR && REG_ADDR == ADDR_CTRL_B) sb_d = REG_WDATA & CTRL_B_WMASK;
      if (REG_WR && REG_ADDR == ADDR_CMP_A) sc_d = REG_WDATA;
   end
   always_ff @(posedge REF_CLK) begin
      if (!NRST) begin
         sa_q <= 8'h00;
         sb_q <= 8'h00;
         sc_q <= 8'h00;
      end else begin
         sa_q <= sa_d;
         sb_q <= sb_d;
         sc_q <= sc_d;
      end
   end
   assign wm = {sb_q[WAVE_HIGH_BIT], sa_q[1:0]};
   assign pwm = wm[0];
   assign run = sb_q[RUN_BIT];
   assign cw = REG_WR && REG_ADDR == ADDR_COUNT;
   assign ea = sa_q[7:6] != 2'h0 && !(pwm && sa_q[7:6] == OM_TOGGLE && !wm[2]);
   assign eb = sa_q[5:4] != 2'h0 && !(pwm && sa_q[5:4] == OM_TOGGLE);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!NRST);
   a_route_chan_a: assert property (CHAN_A_OVERRIDE == ea)
      else $error("channel A override wrong");
   a_route_chan_b: assert property (CHAN_B_OVERRIDE == eb)
      else $error("channel B override wrong");
   a_ctrl_read_back: assert property (REG_RD && REG_ADDR == ADDR_CTRL_A |=>
      REG_RDATA == $past(sa_q)) else $error("control A read wrong");
   a_unmapped_read: assert property (REG_RD && REG_ADDR > ADDR_STATUS |=> REG_RDATA == 8'h00)
      else $error("unmapped read not zero");
   a_reserved_hold: assert property (run && (wm == 3'h4 || wm == 3'h6) && !cw |=>
      $stable(COUNTER_VALUE)) else $error("counter moved in reserved mode");
   a_normal_wrap: assert property (run && wm == WM_NORMAL && COUNTER_VALUE == 8'hff && !cw
      |=> COUNTER_VALUE == 8'h00 ##[0:1] OVERFLOW_FLAG) else $error("normal wrap wrong");
   a_phase_turn: assert property (run && wm == WM_PHASE_FIX && COUNTER_VALUE == 8'hff && !cw
      |=> COUNTER_VALUE == 8'hfe) else $error("phase counter did not turn");
   a_toggle_match: assert property (run && wm == WM_NORMAL && $past(wm) == WM_NORMAL
      && sa_q[7:6] == OM_TOGGLE && COUNTER_VALUE == sc_q && !cw && !$past(cw)
      |=> CHAN_A_WAVE_PIN != $past(CHAN_A_WAVE_PIN)) else $error("toggle missing");
   a_fast_top_set: assert property (run && wm == WM_FAST_FIX && sa_q[7:6] == OM_CLEAR
      && COUNTER_VALUE == 8'hff && !cw |=> CHAN_A_WAVE_PIN) else $error("top set missing");
   c_fast: cover property (run && wm == WM_FAST_FIX);
   c_phase_top: cover property (run && wm == WM_PHASE_FIX && COUNTER_VALUE == 8'hff);
   c_unmapped: cover property (REG_RD && REG_ADDR > ADDR_STATUS);
endmodule

bind tcm_top tcm_props u_props (.REF_CLK(REF_CLK), .NRST(NRST), .REG_ADDR(REG_ADDR),
   .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
   .CHAN_A_WAVE_PIN(CHAN_A_WAVE_PIN), .CHAN_A_OVERRIDE(CHAN_A_OVERRIDE),
   .CHAN_B_WAVE_PIN(CHAN_B_WAVE_PIN), .CHAN_B_OVERRIDE(CHAN_B_OVERRIDE),
   .OVERFLOW_FLAG(OVERFLOW_FLAG), .COUNTER_VALUE(COUNTER_VALUE));

// ===== testbench/tb.sv
// Self-checking bench of the timer compare-output block
module tb;
   import tcm_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic ddr = 1'b1;
   logic [7:0] rdata, cnt;
   logic wa, oa, wb, ob, ovf, pa, pb;
   int failures = 0;
   int check_count = 0;
   int cyc = 0;
   always #2.5 clk = ~clk;
   tcm_top dut (.REF_CLK(clk), .NRST(nrst), .REG_ADDR(addr), .REG_WDATA(wdata),
      .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .CHAN_A_WAVE_PIN(wa),
      .CHAN_A_OVERRIDE(oa), .CHAN_B_WAVE_PIN(wb), .CHAN_B_OVERRIDE(ob),
      .OVERFLOW_FLAG(ovf), .COUNTER_VALUE(cnt));
   tcm_pin_model pin_a (.wave(wa), .ovr(oa), .ddr(ddr), .port_out(1'b0), .pin(pa));
   tcm_pin_model pin_b (.wave(wb), .ovr(ob), .ddr(ddr), .port_out(1'b0), .pin(pb));
   task automatic results();
      if (failures == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Hang guard, well above the total run length
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         results();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rst();
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
   endtask
   task automatic wrr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(16'(rdata), 16'(exp));
   endtask
   task automatic s_regs();
      rst();
      for (int a = 0; a < 8; a++) begin
         rdc(3'(a), 8'h00);
      end
      wrr(ADDR_CTRL_A, 8'hff);
      rdc(ADDR_CTRL_A, 8'hf3);
      wrr(3'h6, 8'hff);
      rdc(3'h6, 8'h00);
   endtask
   task automatic s_ovr();
      logic [2:0] m;
      logic [1:0] c;
      logic ea, eb;
      rst();
      for (int i = 0; i < 32; i++) begin
         m = i[4:2];
         c = i[1:0];
         if (m != 3'h4 && m != 3'h6) begin
            ea = c != 2'h0 && !(m[0] && c == 2'h1 && !m[2]);
            eb = c != 2'h0 && !(m[0] && c == 2'h1);
            wrr(ADDR_CTRL_B, {4'h0, m[2], 3'h0});
            wrr(ADDR_CTRL_A, {c, c, 2'h0, m[1:0]});
            #1;
            chk(16'({oa, ob}), 16'({ea, eb}));
         end
      end
      ddr = 1'b0;
      #1;
      chk(16'(pa), 16'h1);
      ddr = 1'b1;
   endtask
   task automatic s_nonpwm();
      logic [1:0] code [4] = '{2'h1, 2'h2, 2'h3, 2'h1};
      logic ew [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
      logic [7:0] held;
      rst();
      wrr(ADDR_CMP_A, 8'h05);
      wrr(ADDR_CMP_B, 8'h05);
      for (int i = 0; i < 4; i++) begin
         wrr(ADDR_CTRL_B, 8'h00);
         wrr(ADDR_CTRL_A, {code[i], code[i], 4'h0});
         wrr(ADDR_COUNT, 8'h03);
         wrr(ADDR_CTRL_B, 8'h01);
         repeat (8) @(posedge clk);
         #1;
         chk(16'({pa, pb}), 16'({ew[i], ew[i]}));
      end
      wrr(ADDR_COUNT, 8'hfc);
      repeat (8) @(posedge clk);
      #1;
      chk(16'({ovf, cnt}), 16'h104);
      wrr(ADDR_CTRL_A, 8'h02);
      wrr(ADDR_COUNT, 8'h00);
      held = 8'h00;
      repeat (20) begin
         @(posedge clk);
         #1;
         if (cnt > held) held = cnt;
      end
      chk(16'(held), 16'h5);
      wrr(ADDR_CTRL_B, 8'h09);
      #1;
      held = cnt;
      repeat (4) @(posedge clk);
      #1;
      chk(16'(cnt), 16'(held));
   endtask
   // Channel A runs non-inverted, channel B inverted, on the same compare value
   task automatic s_pwm(input logic [2:0] m, input logic [7:0] c, input int per, input int hi);
      int na;
      int nb;
      na = 0;
      nb = 0;
      rst();
      wrr(ADDR_CMP_A, c);
      wrr(ADDR_CMP_B, c);
      wrr(ADDR_CTRL_A, {4'hb, 2'h0, m[1:0]});
      wrr(ADDR_CTRL_B, {4'h0, m[2], 3'h1});
      repeat (600) @(posedge clk);
      repeat (per) begin
         @(posedge clk);
         #1;
         if (wa === 1'b1) na++;
         if (wb === 1'b1) nb++;
      end
      chk(16'(na), 16'(hi));
      chk(16'(nb), 16'(per - hi));
      wrr(ADDR_CTRL_B, {4'h0, m[2], 3'h0});
      #1;
      chk(16'(ovf), 16'h1);
      wrr(ADDR_STATUS, 8'h07);
      #1;
      chk(16'(ovf), 16'h0);
   endtask
   // Channel A code one with the high mode bit toggles once per period
   task automatic s_toggle();
      int na;
      na = 0;
      rst();
      wrr(ADDR_CMP_A, 8'h10);
      wrr(ADDR_CTRL_A, 8'h43);
      wrr(ADDR_CTRL_B, 8'h09);
      repeat (100) @(posedge clk);
      repeat (34) begin
         @(posedge clk);
         #1;
         if (wa === 1'b1) na++;
      end
      chk(16'(na), 16'h11);
      rdc(ADDR_STATUS, 8'h07);
   endtask
   initial begin
      s_regs();
      s_ovr();
      s_nonpwm();
      s_pwm(WM_FAST_FIX, 8'h80, 256, 129);
      s_pwm(WM_FAST_FIX, 8'hff, 256, 256);
      s_pwm(WM_PHASE_FIX, 8'h40, 510, 128);
      s_pwm(WM_PHASE_FIX, 8'hff, 510, 510);
      s_pwm(WM_FAST_CMP, 8'h80, 129, 129);
      s_pwm(WM_PHASE_CMP, 8'h80, 256, 256);
      s_toggle();
      results();
   end
endmodule
